// ---- include/mcr_pkg.sv ----
package mcr_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ            = 25_000_000;
  localparam int FRAME_TYP_MS      = 47;
  localparam int FRAME_MAX_MS      = 60;
  localparam int FRAME_TYP_CYCLES  = (CLK_HZ / 1000) * FRAME_TYP_MS;
  localparam int FRAME_MAX_CYCLES  = (CLK_HZ / 1000) * FRAME_MAX_MS;
  localparam int MCR_SLOT_W        = 21;

  // ****************************************
  // Channels and result format
  // ****************************************
  localparam int MCR_NUM_CH        = 5;
  localparam int MCR_NUM_LIM       = 4;
  localparam int MCR_RAW_W         = 13;
  localparam int MCR_RES_W         = 16;
  localparam int MCR_PAD_W         = 3;
  localparam logic [2:0] MCR_CH_TEMP = 3'h0;
  localparam logic [2:0] MCR_CH_LAST = 3'h4;

  // Limit index within a channel block
  localparam logic [1:0] MCR_LIM_ALARM_HI = 2'h0;
  localparam logic [1:0] MCR_LIM_ALARM_LO = 2'h1;
  localparam logic [1:0] MCR_LIM_WARN_HI  = 2'h2;
  localparam logic [1:0] MCR_LIM_WARN_LO  = 2'h3;

  // ****************************************
  // Register map
  // ****************************************
  localparam int MCR_ADDR_W = 8;
  localparam logic [7:0] MCR_CTRL_OFS    = 8'h00;
  localparam logic [7:0] MCR_DONE_OFS    = 8'h04;
  localparam logic [7:0] MCR_ALARM_OFS   = 8'h08;
  localparam logic [7:0] MCR_WARN_OFS    = 8'h0c;
  localparam logic [7:0] MCR_INT_EN_OFS  = 8'h10;
  localparam logic [7:0] MCR_STATUS_OFS  = 8'h14;
  localparam logic [7:0] MCR_RESULT_OFS  = 8'h20;
  localparam logic [7:0] MCR_RESULT_END  = 8'h34;
  localparam logic [7:0] MCR_LIMIT_OFS   = 8'h40;
  localparam logic [7:0] MCR_LIMIT_END   = 8'h90;

  // Reset values
  localparam logic       MCR_RUN_RST     = 1'b1;
  localparam logic [4:0] MCR_INT_EN_RST  = 5'h00;
  localparam logic [15:0] MCR_LIMIT_RST  = 16'h0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } mcr_bus_req_type;

  typedef struct packed {
    logic       valid;
    logic [2:0] ch;
  } mcr_conv_req_type;

  typedef struct packed {
    logic        valid;
    logic [12:0] data;
  } mcr_conv_res_type;

endpackage

// ---- hdl/mcr_monitor_readout.sv ----
// Function
// - Finished conversion sets that channel's sticky done bit.
// - Each channel has high and low alarm flags and warning flags.
// - Per-channel enable lets an alarm limit violation raise the fault signal.
// - Two buffers copy input pin levels to open-drain output pins.
// - First open-drain output asserts when enabled results exceed alarm limits.
// - Results are 16-bit words with significant bits left-justified.
// - Three least significant result bits always read zero.
// - Channels convert in a fixed rotation, each once per frame.
// - All results compared automatically; flags set within one conversion.
// - Voltage results unsigned, temperature result two's complement.
// - Full scale FFF8 for voltages, 7FF8/8000 for temperature.
// - Step weight 100 uV supply, 38.147 uV external inputs.
// - Full rotation takes about 47 ms, never more than 60 ms.
//
// Chosen here: the strobed register port and the placing of the registers.
module mcr_monitor_readout
  import mcr_pkg::*;
#(
  parameter int FRAME_CYCLES = FRAME_TYP_CYCLES
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire mcr_bus_req_type  bus_req,
  output logic [31:0]           bus_rdata,
  output mcr_conv_req_type      conv_req,
  input  wire mcr_conv_res_type conv_res,
  input  wire logic             buffer_in_a,
  input  wire logic             buffer_in_b,
  output logic                  fault_drain_out_a_o,
  output logic                  fault_drain_out_a_oe,
  output logic                  fault_drain_out_b_o,
  output logic                  fault_drain_out_b_oe
);

  // ****************************************
  // Timing derived from the frame
  // ****************************************
  // Five equal slots per frame keep each channel's refresh period exact
  localparam int SLOT_CYCLES = FRAME_CYCLES / MCR_NUM_CH;
  localparam logic [MCR_SLOT_W-1:0] SLOT_LAST = MCR_SLOT_W'(SLOT_CYCLES - 1);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                             run;
    logic [MCR_SLOT_W-1:0]            slot_cnt;
    logic [2:0]                       next_ch;
    logic [2:0]                       busy_ch;
    logic                             req;
    logic [4:0]                       done;
    logic [4:0]                       al_hi;
    logic [4:0]                       al_lo;
    logic [4:0]                       wn_hi;
    logic [4:0]                       wn_lo;
    logic [4:0]                       int_en;
    logic [4:0][15:0]                 result;
    logic [4:0][3:0][15:0]            limit;
    logic [1:0]                       sync_a;
    logic [1:0]                       sync_b;
    logic                             lvl_a;
    logic                             lvl_b;
    logic [31:0]                      rdata;
  } mcr_state_type;

  mcr_state_type q;
  mcr_state_type d;

  // Signed compare for temperature, unsigned for the voltages
  function automatic logic mcr_above(input logic [15:0] a,
                                     input logic [15:0] b,
                                     input logic        sgn);
    logic res;
    res = sgn ? ($signed(a) > $signed(b)) : (a > b);
    return res;
  endfunction

  logic [15:0] new_res;
  logic        new_sgn;
  logic [7:0]  lim_idx;
  logic [7:0]  res_idx;
  logic [2:0]  acc_ch;
  logic [2:0]  res_ch;
  logic [1:0]  acc_k;
  logic        viol;

  always_comb begin
    d = q;
    d.req = 1'b0;
    lim_idx = bus_req.addr - MCR_LIMIT_OFS;
    res_idx = bus_req.addr - MCR_RESULT_OFS;
    acc_ch = lim_idx[6:4];
    acc_k = lim_idx[3:2];
    res_ch = res_idx[4:2];
    // Padding forces the low bits to zero and left-justifies the code
    new_res = {conv_res.data, {MCR_PAD_W{1'b0}}};
    new_sgn = (q.busy_ch == MCR_CH_TEMP);

    // ****************************************
    // Pin synchronisers and buffers
    // ****************************************
    d.sync_a = {q.sync_a[0], buffer_in_a};
    d.sync_b = {q.sync_b[0], buffer_in_b};
    viol = |(q.int_en & (q.al_hi | q.al_lo));
    d.lvl_a = q.sync_a[1] | viol;
    d.lvl_b = q.sync_b[1];

    // ****************************************
    // Rotation scheduler
    // ****************************************
    if (q.run) begin
      if (q.slot_cnt == SLOT_LAST) begin
        d.slot_cnt = '0;
        d.req = 1'b1;
        d.busy_ch = q.next_ch;
        d.next_ch = (q.next_ch == MCR_CH_LAST) ? 3'h0 : q.next_ch + 3'h1;
      end else begin
        d.slot_cnt = q.slot_cnt + 1'b1;
      end
    end else begin
      d.slot_cnt = '0;
    end

    // ****************************************
    // Register writes
    // ****************************************
    if (bus_req.wr) begin
      if (bus_req.addr == MCR_CTRL_OFS) begin
        d.run = bus_req.wdata[0];
      end else if (bus_req.addr == MCR_DONE_OFS) begin
        d.done = q.done & ~bus_req.wdata[4:0];
      end else if (bus_req.addr == MCR_INT_EN_OFS) begin
        d.int_en = bus_req.wdata[4:0];
      end else if (bus_req.addr >= MCR_LIMIT_OFS && bus_req.addr < MCR_LIMIT_END) begin
        d.limit[acc_ch][acc_k] = bus_req.wdata[15:0];
      end
    end

    // ****************************************
    // Conversion result and compare
    // ****************************************
    // Applied after the write so a new done bit beats a same-cycle clear
    if (conv_res.valid) begin
      d.result[q.busy_ch] = new_res;
      d.done[q.busy_ch] = 1'b1;
      d.al_hi[q.busy_ch] = mcr_above(new_res,
        q.limit[q.busy_ch][MCR_LIM_ALARM_HI], new_sgn);
      d.al_lo[q.busy_ch] = mcr_above(q.limit[q.busy_ch][MCR_LIM_ALARM_LO],
        new_res, new_sgn);
      d.wn_hi[q.busy_ch] = mcr_above(new_res,
        q.limit[q.busy_ch][MCR_LIM_WARN_HI], new_sgn);
      d.wn_lo[q.busy_ch] = mcr_above(q.limit[q.busy_ch][MCR_LIM_WARN_LO],
        new_res, new_sgn);
    end

    // ****************************************
    // Register reads
    // ****************************************
    if (bus_req.rd) begin
      if (bus_req.addr == MCR_CTRL_OFS) begin
        d.rdata = {31'h0, q.run};
      end else if (bus_req.addr == MCR_DONE_OFS) begin
        d.rdata = {27'h0, q.done};
      end else if (bus_req.addr == MCR_ALARM_OFS) begin
        d.rdata = {22'h0, q.al_lo, q.al_hi};
      end else if (bus_req.addr == MCR_WARN_OFS) begin
        d.rdata = {22'h0, q.wn_lo, q.wn_hi};
      end else if (bus_req.addr == MCR_INT_EN_OFS) begin
        d.rdata = {27'h0, q.int_en};
      end else if (bus_req.addr == MCR_STATUS_OFS) begin
        d.rdata = {24'h0, 1'b0, q.next_ch, 1'b0, viol, q.lvl_b, q.lvl_a};
      end else if (bus_req.addr >= MCR_RESULT_OFS && bus_req.addr < MCR_RESULT_END) begin
        d.rdata = {16'h0, q.result[res_ch]};
      end else if (bus_req.addr >= MCR_LIMIT_OFS && bus_req.addr < MCR_LIMIT_END) begin
        d.rdata = {16'h0, q.limit[acc_ch][acc_k]};
      end else begin
        d.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.run <= MCR_RUN_RST;
      q.int_en <= MCR_INT_EN_RST;
      q.limit <= {(MCR_NUM_CH * MCR_NUM_LIM){MCR_LIMIT_RST}};
      // Released pins read high so the outputs stay off through reset
      q.sync_a <= 2'h3;
      q.sync_b <= 2'h3;
      q.lvl_a <= 1'b1;
      q.lvl_b <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Open drain: a high level is shown by releasing the pin
  assign bus_rdata = q.rdata;
  assign conv_req = '{valid: q.req, ch: q.busy_ch};
  assign fault_drain_out_a_o = 1'b0;
  assign fault_drain_out_a_oe = ~q.lvl_a;
  assign fault_drain_out_b_o = 1'b0;
  assign fault_drain_out_b_oe = ~q.lvl_b;

endmodule

// ---- dv/mcr_conv_model.sv ----
module mcr_conv_model
  import mcr_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire mcr_conv_req_type conv_req,
  input  wire logic [4:0][12:0] codes,
  input  wire logic [2:0]       lag,
  output mcr_conv_res_type      conv_res
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Converter: one code per request
  // ****************************************
  logic [2:0]  ch_q;
  logic [2:0]  wait_q;
  logic        busy_q;
  logic [12:0] last_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_res <= '0;
      busy_q   <= 1'b0;
      wait_q   <= 3'h0;
      ch_q     <= 3'h0;
      last_q   <= 13'h0;
    end else begin
      conv_res.valid <= 1'b0;
      // Stale code is inverted so it never passes for a fresh one
      conv_res.data  <= ~last_q;
      if (conv_req.valid) begin
        busy_q <= 1'b1;
        wait_q <= lag;
        ch_q   <= conv_req.ch;
      end else if (busy_q && wait_q == 3'h0) begin
        busy_q         <= 1'b0;
        conv_res.valid <= 1'b1;
        conv_res.data  <= codes[ch_q];
        last_q         <= codes[ch_q];
      end else if (busy_q) begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end
endmodule

// ---- dv/mcr_readout_monitor.sv ----
module mcr_readout_monitor
  import mcr_pkg::*;
#(
  parameter int FRAME_CYCLES = 50
) (
  input wire logic             ref_clk,
  input wire logic             arst_n,
  input wire mcr_bus_req_type  bus_req,
  input wire logic [31:0]      bus_rdata,
  input wire mcr_conv_req_type conv_req,
  input wire logic             buffer_in_a,
  input wire logic             buffer_in_b,
  input wire logic             fault_drain_out_a_o,
  input wire logic             fault_drain_out_a_oe,
  input wire logic             fault_drain_out_b_o,
  input wire logic             fault_drain_out_b_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Helpers and checks
  // ****************************************
  logic [2:0]  last_q;
  logic [MCR_SLOT_W-1:0] gap_q;
  logic [2:0]  up_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_q <= 3'h4;
      gap_q  <= '0;
      up_q   <= 3'h0;
    end else begin
      last_q <= conv_req.valid ? conv_req.ch : last_q;
      gap_q  <= conv_req.valid ? '0 : gap_q + 1'b1;
      up_q   <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Pins are only trusted once the synchroniser has filled
  sequence settled;
    up_q == 3'h7;
  endsequence
  sequence result_read;
    bus_req.rd && bus_req.addr >= MCR_RESULT_OFS && bus_req.addr <= 8'h30;
  endsequence
  rot_order_a: assert property (conv_req.valid |-> conv_req.ch ==
    ((last_q == MCR_CH_LAST) ? 3'h0 : last_q + 3'h1)) else $error("rotation out of order");
  slot_gap_a: assert property (conv_req.valid |-> gap_q >= FRAME_CYCLES / 5 - 1)
    else $error("conversions too close");
  ch_hold_a: assert property (!conv_req.valid |-> $stable(conv_req.ch))
    else $error("channel moved without request");
  pad_zero_a: assert property (result_read |=> bus_rdata[2:0] == 3'h0
    && bus_rdata[31:16] == 16'h0) else $error("result padding not zero");
  rdata_hold_a: assert property (!$past(bus_req.rd) |-> $stable(bus_rdata))
    else $error("read data changed without read");
  drain_low_a: assert property (!fault_drain_out_a_o && !fault_drain_out_b_o)
    else $error("open drain drives high");
  buf_b_a: assert property (settled |-> fault_drain_out_b_oe == !$past(buffer_in_b, 3))
    else $error("buffer b level wrong");
  buf_a_a: assert property (settled ##0 $past(buffer_in_a, 3) |-> !fault_drain_out_a_oe)
    else $error("buffer a not released");
endmodule
bind mcr_monitor_readout mcr_readout_monitor #(.FRAME_CYCLES(FRAME_CYCLES)) chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .conv_req(conv_req), .buffer_in_a(buffer_in_a), .buffer_in_b(buffer_in_b),
  .fault_drain_out_a_o(fault_drain_out_a_o), .fault_drain_out_a_oe(fault_drain_out_a_oe),
  .fault_drain_out_b_o(fault_drain_out_b_o), .fault_drain_out_b_oe(fault_drain_out_b_oe));

// ---- dv/monitor_channel_readout_test.sv ----
module monitor_channel_readout_test
  import mcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic             ref_clk = 1'b0;
  logic             arst_n = 1'b0;
  logic             buffer_in_a = 1'b0;
  logic             buffer_in_b = 1'b0;
  logic             blink = 1'b0;
  logic [2:0]       lag = 3'h0;
  mcr_bus_req_type  bus_req = '0;
  logic [31:0]      bus_rdata;
  logic [31:0]      rdv;
  mcr_conv_req_type conv_req;
  mcr_conv_res_type conv_res;
  logic             a_oe;
  logic             b_oe;
  int               bad_count = 0;
  int               total_checks = 0;
  int               cyc = 0;
  logic [4:0][12:0] codes = {13'h1555, 13'h0aaa, 13'h0000, 13'h1fff, 13'h1000};
  logic [15:0]      exp_res [5] = '{16'h8000, 16'hfff8, 16'h0000, 16'h5550, 16'haaa8};
  logic [4:0]       masks [3] = '{5'h02, 5'h04, 5'h00};
  always #20 ref_clk = ~ref_clk;
  // Pin toggles every 160 ns, on a falling clock edge away from the sampling edge
  always #160 if (blink) buffer_in_b = ~buffer_in_b;
  mcr_monitor_readout #(.FRAME_CYCLES(50)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .conv_req(conv_req), .conv_res(conv_res),
    .buffer_in_a(buffer_in_a), .buffer_in_b(buffer_in_b), .fault_drain_out_a_o(),
    .fault_drain_out_a_oe(a_oe), .fault_drain_out_b_o(), .fault_drain_out_b_oe(b_oe));
  mcr_conv_model model (.ref_clk(ref_clk), .arst_n(arst_n), .conv_req(conv_req),
    .codes(codes), .lag(lag), .conv_res(conv_res));
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    bus_req <= '0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    bus_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge ref_clk);
    bus_req <= '0;
    @(posedge ref_clk);
    rdv = bus_rdata;
  endtask
  task automatic close_out();
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(MCR_CTRL_OFS);
    check("ctrl", rdv, 32'h1);
    rd(MCR_INT_EN_OFS);
    check("int_en", rdv, 32'h0);
    repeat (60) @(posedge ref_clk);
    lag <= 3'h7;
    repeat (60) @(posedge ref_clk);
    for (int i = 0; i < 5; i++) begin
      rd(MCR_RESULT_OFS + 8'(4 * i));
      check("result", rdv, {16'h0, exp_res[i]});
      check("host value", rdv & 32'h0000_fff0, {16'h0, exp_res[i] & 16'hfff0});
    end
    rd(MCR_DONE_OFS);
    check("done", rdv, 32'h1f);
    wr(8'h24, 32'h1234);
    rd(8'h24);
    check("result ro", rdv, 32'hfff8);
    wr(8'h50, 32'h8000);
    wr(8'h64, 32'h10);
    wr(8'h7c, 32'hffff);
    repeat (60) @(posedge ref_clk);
    rd(MCR_ALARM_OFS);
    check("alarm", rdv, 32'h0ba);
    rd(MCR_WARN_OFS);
    check("warn", rdv, 32'h13a);
    foreach (masks[i]) begin
      wr(MCR_INT_EN_OFS, {27'h0, masks[i]});
      repeat (4) @(posedge ref_clk);
      check("oe_a", {31'h0, a_oe}, {31'h0, masks[i] == 5'h0});
    end
    buffer_in_a <= 1'b1;
    repeat (5) @(posedge ref_clk);
    check("oe_a pin", {31'h0, a_oe}, 32'h0);
    buffer_in_a <= 1'b0;
    blink <= 1'b1;
    repeat (100) @(posedge ref_clk);
    blink <= 1'b0;
    // Output trails the pin by three edges, so let the last toggle settle
    repeat (4) @(posedge ref_clk);
    check("oe_b", {31'h0, b_oe}, {31'h0, ~buffer_in_b});
    wr(MCR_CTRL_OFS, 32'h0);
    // A conversion requested just before the stop may still land
    repeat (12) @(posedge ref_clk);
    wr(MCR_DONE_OFS, 32'h1f);
    rd(MCR_DONE_OFS);
    check("done clear", rdv, 32'h0);
    repeat (30) @(posedge ref_clk);
    rd(MCR_DONE_OFS);
    check("done stopped", rdv, 32'h0);
    wr(MCR_CTRL_OFS, 32'h1);
    repeat (30) @(posedge ref_clk);
    arst_n <= 1'b0;
    @(posedge ref_clk);
    check("oe_a rst", {31'h0, a_oe}, 32'h0);
    check("oe_b rst", {31'h0, b_oe}, 32'h0);
    @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(MCR_ALARM_OFS);
    check("alarm rst", rdv, 32'h0);
    close_out();
  end
endmodule
